// file: crc32_checker.sv
/*
 crc32_checker: apb configured crc32 engine fed by a dma source stream,
 optional forward to a dma destination stream, verify and fill modes.
 assumes one clock pclk, dma channels on the same clock, apb master.
*/
// Contract
// - crc32 computed over each 32-bit word, accumulated across the block
// - transfer mode optionally forwards each word to the destination, still signed
// - in scan and transfer modes the final signature is compared to expected value; mismatch raises fault event
// - fault routed either to fault_irq or trigger router, while the summary irq takes a masked fault on both routes
// - polynomial is software programmable
// - selectable bit mirroring and byte mirroring of incoming data
// - fill mode generates constant words for 1d and 2d blocks
// - separate fault and error interrupt outputs
// - one 32-bit signature covers whole block, memory or register space
`timescale 1ns/10ps
module crc32_checker
#(
   parameter int count_width = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        src_valid,
   input  wire logic [31:0] src_data,
   output logic             src_ready,
   output logic             dst_valid,
   output logic      [31:0] dst_data,
   input  wire logic        dst_ready,
   output logic             irq,
   output logic             fault_irq,
   output logic             err_irq,
   output logic             trigger_router
);
   import crc_pkg::*;

   if (count_width < 1 || count_width > 32) begin : g_width_check
      $error("count_width out of range");
   end

   typedef enum logic [1:0] {st_idle, st_run, st_done} state_e;

   state_e                 state;
   logic [31:0]            ctl;
   logic [31:0]            poly;
   logic [31:0]            seed;
   logic [31:0]            expect_val;
   logic [31:0]            const_val;
   logic [count_width-1:0] count;
   logic [count_width-1:0] rows;
   logic [count_width-1:0] col_left;
   logic [count_width-1:0] row_left;
   logic [31:0]            crc;
   logic [st_width-1:0]    stat;
   logic [st_width-1:0]    mask;
   logic [st_width-1:0]    stat_clr;
   logic [st_width-1:0]    stat_set;
   logic                   err_seen;
   logic [31:0]            prepped;
   logic [31:0]            next_crc;
   logic [31:0]            word_in;
   logic                   word_fire;
   logic                   last_word;
   logic                   fill_mode;
   logic                   fwd_on;
   logic                   ev_done;
   logic                   ev_fault;
   logic                   ev_err;
   mode_e                  mode;

   wire wr_en = psel && penable && pwrite;
   wire go_wr = wr_en && paddr == ctl_off && pwdata[ctl_go_bit];

   assign mode      = mode_e'(ctl[ctl_mode_lo +: 2]);
   assign fill_mode = (mode == mode_fill);
   assign fwd_on    = (mode == mode_xfer) && ctl[ctl_fwd_bit];
   // zero wait states: every access ends in its first access cycle
   assign pready    = 1'b1;

   // fill words come from the constant, else from the dma source
   assign word_in = fill_mode ? const_val : prepped;

   crc_word_prep u_prep (
      .din         (src_data),
      .bit_mirror  (ctl[ctl_bitmir_bit]),
      .byte_mirror (ctl[ctl_bytmir_bit]),
      .dout        (prepped)
   );

   crc_word_step u_step (
      .crc_in  (crc),
      .data    (word_in),
      .poly    (poly),
      .crc_out (next_crc)
   );

   // source stalls while the destination cannot take a forwarded word
   assign src_ready = (state == st_run) && !fill_mode && (!fwd_on || !dst_valid || dst_ready);
   assign word_fire = (state == st_run) &&
                      (fill_mode ? (!dst_valid || dst_ready) : (src_valid && src_ready));
   assign last_word = (col_left == count_width'(1)) && (row_left == count_width'(1));

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl        <= zero_word;
         poly       <= poly_reset;
         seed       <= seed_reset;
         expect_val <= zero_word;
         const_val  <= zero_word;
         count      <= '0;
         rows       <= '0;
         mask       <= '0;
      end else if (wr_en) begin
         case (paddr)
            ctl_off:    ctl        <= pwdata & ~(32'h1 << ctl_go_bit);
            poly_off:   poly       <= pwdata;
            seed_off:   seed       <= pwdata;
            expect_off: expect_val <= pwdata;
            const_off:  const_val  <= pwdata;
            count_off:  count      <= pwdata[count_width-1:0];
            rows_off:   rows       <= pwdata[count_width-1:0];
            mask_off:   mask       <= pwdata[st_width-1:0];
            default:    ;
         endcase
      end
   end

   // block sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= st_idle;
         crc      <= zero_word;
         col_left <= '0;
         row_left <= '0;
         err_seen <= 1'b0;
      end else begin
         case (state)
            st_idle, st_done: begin
               // a zero count is ignored so a stray go cannot open an empty block
               if (go_wr && count != '0) begin
                  state    <= st_run;
                  crc      <= seed;
                  col_left <= count;
                  row_left <= (rows == '0) ? count_width'(1) : rows;
                  err_seen <= 1'b0;
               end
            end
            st_run: begin
               if (word_fire) begin
                  crc <= next_crc;
                  if (mode == mode_verify && word_in != const_val)
                     err_seen <= 1'b1;
                  if (last_word) begin
                     state <= st_done;
                  end else if (col_left == count_width'(1)) begin
                     col_left <= count;
                     row_left <= row_left - count_width'(1);
                  end else begin
                     col_left <= col_left - count_width'(1);
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // a single holding stage; a stalled destination holds back the source
   // forwarded or filled word toward the destination channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dst_valid <= 1'b0;
         dst_data  <= zero_word;
      end else if (word_fire && (fwd_on || fill_mode)) begin
         dst_valid <= 1'b1;
         dst_data  <= fill_mode ? const_val : src_data;
      end else if (dst_ready) begin
         dst_valid <= 1'b0;
      end
   end

   // fault uses next_crc so the verdict lands with the last word
   assign ev_done  = word_fire && last_word;
   assign ev_fault = ev_done && mode != mode_verify && !fill_mode &&
                     next_crc != expect_val;
   assign ev_err   = word_fire && mode == mode_verify && !err_seen &&
                     word_in != const_val;

   // sticky status, write one to clear, a new event wins over the clear
   assign stat_clr = (wr_en && paddr == stat_off) ? pwdata[st_width-1:0] : '0;
   always_comb begin
      stat_set               = '0;
      stat_set[st_done_bit]  = ev_done;
      stat_set[st_fault_bit] = ev_fault;
      stat_set[st_err_bit]   = ev_err;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat <= '0;
      end else begin
         stat <= (stat & ~stat_clr) | stat_set;
      end
   end

   // the trigger router path ignores the mask, the event fabric has its own
   // routing bit picks fault_irq or trigger router for the fault; irq takes it by mask alone on both routes
   assign irq            = |(stat & mask);
   assign fault_irq      = stat[st_fault_bit] && mask[st_fault_bit] &&
                           !ctl[ctl_route_bit];
   assign trigger_router = stat[st_fault_bit] && ctl[ctl_route_bit];
   assign err_irq        = stat[st_err_bit] && mask[st_err_bit];

   // read mux, unmapped addresses read zero with no error
   always_comb begin
      prdata = zero_word;
      case (paddr)
         ctl_off:    prdata = ctl;
         poly_off:   prdata = poly;
         seed_off:   prdata = seed;
         expect_off: prdata = expect_val;
         const_off:  prdata = const_val;
         count_off:  prdata = 32'(count);
         rows_off:   prdata = 32'(rows);
         result_off: prdata = crc;
         stat_off:   prdata = 32'(stat);
         mask_off:   prdata = 32'(mask);
         state_off:  prdata = {30'h0, state == st_done, state == st_run};
         default:    prdata = zero_word;
      endcase
   end
   assign pslverr = 1'b0;

   // checks on the sequencer, status and stream handshakes
   a_seed_load: assert property (@(posedge pclk) disable iff (!presetn)
      state != st_run ##1 state == st_run |-> crc == seed)
      else $error("seed not loaded at block start");
   a_crc_step: assert property (@(posedge pclk) disable iff (!presetn)
      word_fire |=> crc == $past(next_crc))
      else $error("crc not accumulated");
   a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ev_fault |=> stat[st_fault_bit])
      else $error("fault not flagged");
   a_fault_route: assert property (@(posedge pclk) disable iff (!presetn)
      stat[st_fault_bit] && ctl[ctl_route_bit] |-> trigger_router && !fault_irq)
      else $error("fault routed wrong");
   a_err_first: assert property (@(posedge pclk) disable iff (!presetn)
      ev_err |=> err_seen && stat[st_err_bit])
      else $error("verify error not raised");
   a_fwd_word: assert property (@(posedge pclk) disable iff (!presetn)
      word_fire && fwd_on |=> dst_valid && dst_data == $past(src_data))
      else $error("word not forwarded");
   a_fill_word: assert property (@(posedge pclk) disable iff (!presetn)
      dst_valid && fill_mode |-> dst_data == const_val)
      else $error("fill word wrong");
   a_done_stop: assert property (@(posedge pclk) disable iff (!presetn)
      ev_done |=> state == st_done ##1 !word_fire)
      else $error("block did not end");
   a_err_irq: assert property (@(posedge pclk) disable iff (!presetn)
      stat[st_err_bit] && mask[st_err_bit] |-> err_irq && irq)
      else $error("error interrupt missing");
   a_src_idle: assert property (@(posedge pclk) disable iff (!presetn)
      state != st_run |-> !src_ready && !word_fire)
      else $error("stream active outside a block");
   a_start_count: assert property (@(posedge pclk) disable iff (!presetn)
      go_wr && count == '0 && state != st_run |=> state != st_run)
      else $error("empty block started");
   a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
      state != st_run ##1 state == st_run |-> col_left == count)
      else $error("word count not loaded");
   a_row_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      word_fire && col_left == count_width'(1) && !last_word |=> col_left == count)
      else $error("row did not wrap");
   a_fill_nosrc: assert property (@(posedge pclk) disable iff (!presetn)
      fill_mode |-> !src_ready)
      else $error("source taken in fill mode");
   a_dst_hold: assert property (@(posedge pclk) disable iff (!presetn)
      dst_valid && !dst_ready |=> dst_valid && $stable(dst_data))
      else $error("destination word dropped");
   a_fault_core: assert property (@(posedge pclk) disable iff (!presetn)
      stat[st_fault_bit] && mask[st_fault_bit] && !ctl[ctl_route_bit] |->
      fault_irq && !trigger_router)
      else $error("fault not routed to core");
   a_fault_mode: assert property (@(posedge pclk) disable iff (!presetn)
      ev_fault |-> mode == mode_scan || mode == mode_xfer)
      else $error("fault outside scan or transfer");
   a_raw_path: assert property (@(posedge pclk) disable iff (!presetn)
      !fill_mode && !ctl[ctl_bitmir_bit] && !ctl[ctl_bytmir_bit] |-> word_in == src_data)
      else $error("word altered without mirroring");

   c_scan_done: cover property (@(posedge pclk) ev_done && mode == mode_scan);
   c_fault:     cover property (@(posedge pclk) ev_fault);
   c_verify:    cover property (@(posedge pclk) ev_err);
   c_fill_2d:   cover property (@(posedge pclk) ev_done && fill_mode && rows > count_width'(1));
   c_xfer_fwd:  cover property (@(posedge pclk) word_fire && fwd_on);
endmodule

// file: crc32_checker_tb.sv
/*
 crc32_checker_tb: self-checking bench for the crc block over apb.
 assumes dma_model on the stream side and zero-wait apb answers.
*/
`timescale 1ns/10ps
module crc32_checker_tb;
   import crc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
   logic        src_valid, src_ready, dst_valid, dst_ready;
   logic        irq, fault_irq, err_irq, trigger_router, wrong, rt, bm, ym, fw;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, src_data, dst_data, rd_val, poly, crc, w, cv;
   logic [32:0] rq[$];
   logic [31:0] dq[$];
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          seed = 32'h7563;

   crc32_checker uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
      .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready), .irq(irq),
      .fault_irq(fault_irq), .err_irq(err_irq), .trigger_router(trigger_router));

   dma_model u_dma (.pclk(pclk), .presetn(presetn), .slow(slow), .src_ready(src_ready),
      .src_valid(src_valid), .src_data(src_data), .dst_ready(dst_ready));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] step(logic [31:0] c, d, p, logic b, y);
      logic [31:0] x;
      x = y ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      x = b ? {<<{x}} : x;
      c = c ^ x;
      for (int i = 0; i < 32; i++) begin
         c = c[31] ? ((c << 1) ^ p) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [31:0] ctl(mode_e m, logic b, y, f, r);
      return {25'h0, r, f, y, b, m, 1'b1};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int t;
      if (!wr) rq.push_back(e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd_val = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b1, e});
   endtask

   // poll without comparing; a hang ends the run
   task automatic wait_done;
      int t;
      rd_val = 32'h0;
      for (t = 0; t < 200 && rd_val[st_done_bit] !== 1'b1; t++) apb(1'b0, stat_off, 0, 0);
      if (t >= 200) begin
         n_mismatch++;
         tally_and_finish;
      end
      for (t = 0; t < 100 && dq.size() != 0; t++) @(posedge pclk);
      if (dq.size() != 0) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask

   // results are compared as they appear, against the oldest note
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready && !pwrite && rq.size() != 0) begin
         if (rq[0][32]) chk("prdata", prdata, rq[0][31:0]);
         void'(rq.pop_front());
      end
      if (presetn && dst_valid && dst_ready) begin
         if (dq.size() != 0) chk("dst_data", dst_data, dq.pop_front());
         else chk("dst_extra", 32'h1, 32'h0);
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, slow, presetn} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(poly_off, poly_reset);
      rd(seed_off, seed_reset);
      wr(12'h030, 32'hffffffff);
      rd(12'h030, zero_word);
      chk("pslverr", pslverr, 0);
      // scan, transfer with and without forwarding, all mirror pairs, both routes
      for (int k = 0; k < 4; k++) begin
         poly = $random(seed) | 1;
         crc = $random(seed);
         {wrong, rt, bm, ym, fw} = {k[0], k[1], k[1], k[0] ^ k[1], k[0] & !k[1]};
         slow <= k[0] ^ k[1];
         wr(poly_off, poly);
         wr(seed_off, crc);
         for (int i = 0; i < k + 2; i++) begin
            w = $random(seed);
            crc = step(crc, w, poly, bm, ym);
            u_dma.push(w);
            if (fw) dq.push_back(w);
         end
         wr(expect_off, crc ^ {31'h0, wrong});
         wr(count_off, k + 2);
         wr(mask_off, (k == 2) ? 0 : 7);
         wr(ctl_off, ctl(wrong ? mode_xfer : mode_scan, bm, ym, fw, rt));
         wait_done;
         rd(result_off, crc);
         rd(stat_off, {30'h0, wrong, 1'b1});
         chk("fault_irq", fault_irq, wrong & !rt);
         chk("trigger_router", trigger_router, wrong & rt);
         chk("irq", irq, k != 2);
         wr(stat_off, 7);
         rd(stat_off, 0);
         chk("irq_clr", irq, 0);
      end
      // verify: one word off the constant
      slow <= 1'b1;
      cv = $random(seed);
      for (int i = 0; i < 4; i++) u_dma.push((i == 1) ? cv ^ 1 : cv);
      wr(const_off, cv);
      wr(count_off, 4);
      wr(ctl_off, ctl(mode_verify, 0, 0, 0, 0));
      wait_done;
      rd(stat_off, 32'h5);
      chk("err_irq", err_irq, 1);
      wr(stat_off, 7);
      // 2d fill of 3 by 2, destination stalling
      crc = $random(seed);
      wr(seed_off, crc);
      for (int i = 0; i < 6; i++) crc = step(crc, cv, poly, 0, 0);
      for (int i = 0; i < 6; i++) dq.push_back(cv);
      wr(count_off, 3);
      wr(rows_off, 2);
      wr(ctl_off, ctl(mode_fill, 0, 0, 0, 0));
      wait_done;
      rd(result_off, crc);
      chk("fill_left", dq.size(), 0);
      tally_and_finish;
   end
endmodule

// file: crc_pkg.sv
/*
 crc_pkg: register offsets, field positions, reset values and mode codes
 for the dma fed crc32 checker. assumes a 32-bit apb register bus.
*/
package crc_pkg;
   localparam logic [11:0] ctl_off    = 12'h000;
   localparam logic [11:0] poly_off   = 12'h004;
   localparam logic [11:0] seed_off   = 12'h008;
   localparam logic [11:0] expect_off = 12'h00c;
   localparam logic [11:0] const_off  = 12'h010;
   localparam logic [11:0] count_off  = 12'h014;
   localparam logic [11:0] rows_off   = 12'h018;
   localparam logic [11:0] result_off = 12'h01c;
   localparam logic [11:0] stat_off   = 12'h020;
   localparam logic [11:0] mask_off   = 12'h024;
   localparam logic [11:0] state_off  = 12'h028;

   // ctl fields
   localparam int ctl_go_bit     = 0;
   localparam int ctl_mode_lo    = 1;
   localparam int ctl_bitmir_bit = 3;
   localparam int ctl_bytmir_bit = 4;
   localparam int ctl_fwd_bit    = 5;
   localparam int ctl_route_bit  = 6;

   // status / mask fields
   localparam int st_done_bit  = 0;
   localparam int st_fault_bit = 1;
   localparam int st_err_bit   = 2;
   localparam int st_width     = 3;

   localparam logic [31:0] poly_reset = 32'h04c11db7;
   localparam logic [31:0] seed_reset = 32'hffffffff;
   localparam logic [31:0] zero_word  = 32'h00000000;

   typedef enum logic [1:0] {
      mode_scan,
      mode_xfer,
      mode_verify,
      mode_fill
   } mode_e;

   function automatic logic [31:0] mirror_bits(input logic [31:0] d);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = d[31-i];
      end
      return r;
   endfunction

   function automatic logic [31:0] swap_bytes(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction
endpackage

// file: crc_word_prep.sv
/*
 crc_word_prep: applies the optional bit and byte mirroring to an
 incoming word so either endianness of the memory image can be signed.
*/
`timescale 1ns/10ps
module crc_word_prep
   import crc_pkg::*;
(
   input  wire logic [31:0] din,
   input  wire logic        bit_mirror,
   input  wire logic        byte_mirror,
   output logic      [31:0] dout
);
   always_comb begin
      logic [31:0] t;
      t = byte_mirror ? swap_bytes(din) : din;
      dout = bit_mirror ? mirror_bits(t) : t;
   end
endmodule

// file: crc_word_step.sv
/*
 crc_word_step: one-cycle crc32 update of a 32-bit word, msb first,
 with a programmable polynomial. purely combinational; caller registers.
*/
`timescale 1ns/10ps
module crc_word_step (
   input  wire logic [31:0] crc_in,
   input  wire logic [31:0] data,
   input  wire logic [31:0] poly,
   output logic      [31:0] crc_out
);
   always_comb begin
      logic [31:0] c;
      c = crc_in ^ data;
      for (int i = 0; i < 32; i++) begin
         c = c[31] ? ((c << 1) ^ poly) : (c << 1);
      end
      crc_out = c;
   end
endmodule

// file: dma_model.sv
/*
 dma_model: stand-in for the dma source and destination channels.
 assumes pclk is shared with the crc block; slow adds gaps and stalls.
*/
`timescale 1ns/10ps
module dma_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   input  wire logic        src_ready,
   output logic             src_valid,
   output logic      [31:0] src_data,
   output logic             dst_ready
);
   logic [31:0] words[$];
   int          seed = 32'h7563;

   task automatic push(input logic [31:0] w);
      words.push_back(w);
   endtask

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_valid <= 1'b0;
         src_data  <= 32'h00000000;
         dst_ready <= 1'b0;
      end else begin
         dst_ready <= !slow || ($random(seed) & 1);
         if (src_valid && src_ready) begin
            void'(words.pop_front());
         end
         // a word once offered is held until taken
         if (!src_valid || src_ready) begin
            if (words.size() != 0 && (!slow || ($random(seed) & 1))) begin
               src_valid <= 1'b1;
               src_data  <= words[0];
            end else begin
               // no stale word left on an idle bus
               src_valid <= 1'b0;
               src_data  <= ~src_data;
            end
         end
      end
   end
endmodule
